// file: logic/ceb_pkg.sv
package ceb_pkg;

  // Datapath widths.
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int PC_W = 16;
  localparam int KOFF_W = 7;
  localparam int WIMM_W = 6;
  localparam int BSEL_W = 3;
  localparam int CYC_W = 3;

  // Bit positions inside the status flags register.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Bit positions used by the flag equations.
  localparam int NIB_MSB = 3;
  localparam int BYTE_MSB = 7;
  localparam int WORD_MSB = 15;

  // Cycle counts per instruction class.
  localparam logic [CYC_W-1:0] CYC_ONE = 3'h1;
  localparam logic [CYC_W-1:0] CYC_TWO = 3'h2;
  localparam logic [CYC_W-1:0] CYC_THREE = 3'h3;
  localparam logic [CYC_W-1:0] CYC_CALL = 3'h4;
  localparam logic [CYC_W-1:0] CYC_NONE = 3'h0;

  // Program counter steps in words.
  localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
  localparam logic [PC_W-1:0] PC_SKIP_ONE = 16'h0002;
  localparam logic [PC_W-1:0] PC_SKIP_TWO = 16'h0003;

  localparam logic [DATA_W-1:0] ALL_ONES = 8'hff;
  localparam logic [DATA_W-1:0] ALL_ZERO = 8'h00;

  typedef enum logic [4:0] {
    OP_ADD_CARRY         = 5'h00,
    OP_WORD_ADD_IMM      = 5'h01,
    OP_WORD_SUB_IMM      = 5'h02,
    OP_SUB_WITH_BORROW   = 5'h03,
    OP_SUB_IMM_BORROW    = 5'h04,
    OP_SUB_IMMEDIATE     = 5'h05,
    OP_MASK_IMMEDIATE    = 5'h06,
    OP_MERGE_IMMEDIATE   = 5'h07,
    OP_BIT_SET_MASK      = 5'h08,
    OP_BIT_CLEAR_MASK    = 5'h09,
    OP_ZERO_SIGN_TEST    = 5'h0a,
    OP_MIXED_PRODUCT     = 5'h0b,
    OP_MIXED_FRACTION    = 5'h0c,
    OP_POINTER_JUMP      = 5'h0d,
    OP_POINTER_CALL      = 5'h0e,
    OP_SKIP_REG_BIT_LOW  = 5'h0f,
    OP_SKIP_REG_BIT_HIGH = 5'h10,
    OP_SKIP_IO_BIT_LOW   = 5'h11,
    OP_SKIP_IO_BIT_HIGH  = 5'h12,
    OP_BRANCH_FLAG_HIGH  = 5'h13,
    OP_BRANCH_FLAG_LOW   = 5'h14,
    OP_COMPARE_IMMEDIATE = 5'h15,
    OP_BRANCH_UNSIGNED_GE = 5'h16,
    OP_BRANCH_NO_CARRY   = 5'h17
  } ceb_op_t;

  // One decoded instruction with all operands fetched.
  typedef struct packed {
    ceb_op_t op;
    logic [DATA_W-1:0] dst;
    logic [DATA_W-1:0] src;
    logic [WORD_W-1:0] pair;
    logic [WORD_W-1:0] zptr;
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] flags;
    logic [BSEL_W-1:0] bit_sel;
    logic [DATA_W-1:0] io_byte;
    logic [KOFF_W-1:0] k_off;
    logic next_two_word;
  } ceb_req_t;

  // Write-back of one finished instruction.
  typedef struct packed {
    logic dst_we;
    logic [DATA_W-1:0] dst_val;
    logic pair_we;
    logic [WORD_W-1:0] pair_val;
    logic prod_we;
    logic [WORD_W-1:0] prod_val;
    logic [DATA_W-1:0] flags_val;
    logic [PC_W-1:0] pc_val;
    logic push_we;
    logic [PC_W-1:0] push_val;
  } ceb_res_t;

  typedef struct packed {
    logic [DATA_W-1:0] val;
    logic h;
    logic v;
    logic c;
  } ceb_alu_t;

endpackage

// file: logic/ceb_mixed_mul.sv
`timescale 1ns/10ps

// Signed-by-unsigned 8x8 multiply with optional fractional shift.
module ceb_mixed_mul (
  // Operands.
  input wire logic [ceb_pkg::DATA_W-1:0] signed_i,
  input wire logic [ceb_pkg::DATA_W-1:0] unsigned_i,
  input wire logic fraction_i,
  // Product and flags.
  output logic [ceb_pkg::WORD_W-1:0] product_o,
  output logic carry_o,
  output logic zero_o
);

  logic signed [ceb_pkg::WORD_W:0] wide;
  logic [ceb_pkg::WORD_W-1:0] raw;

  // The unsigned operand gets a zero sign bit so it never turns negative.
  assign wide = $signed(signed_i) * $signed({1'b0, unsigned_i});
  assign raw = wide[ceb_pkg::WORD_W-1:0];
  // Carry is the top bit before the fractional shift drops it.
  assign carry_o = raw[ceb_pkg::WORD_MSB];
  assign product_o = fraction_i ? {raw[ceb_pkg::WORD_MSB-1:0], 1'b0} : raw;
  assign zero_o = (product_o == '0);

endmodule // ceb_mixed_mul

// file: logic/ceb_execute.sv
`timescale 1ns/10ps

// What this block does
// - Add with carry: dst+src+C into dst, flags Z C N V H, one cycle.
// - Word add immediate on high:low pair, flags Z C N V S, two cycles.
// - Word subtract immediate, written back to pair, flags Z C N V S, two cycles.
// - Register subtract with borrow dst-src-C, flags Z C N V H, one cycle.
// - Immediate subtract with borrow dst-K-C into dst, flags Z C N V H, one cycle.
// - Subtract immediate dst-K into dst, flags Z C N V H, one cycle.
// - Mask immediate ANDs constant, only Z N V change, one cycle.
// - Merge immediate ORs constant, only Z N V change, one cycle.
// - Bit set mask equals OR with constant, flags Z N V, one cycle.
// - Bit clear mask ANDs with 0xFF minus constant, flags Z N V, one cycle.
// - Zero sign test ANDs register with itself, value kept, Z N V, one cycle.
// - Mixed sign product, signed by unsigned into R1:R0, Z C, two cycles.
// - Mixed fraction product, same product shifted left one, Z C, two cycles.
// - Pointer jump loads PC from Z pointer, no flags, two cycles.
// - Pointer call loads PC from Z, pushes return point, four cycles.
// - Skip when register bit low, PC plus 2 or 3, 1/2/3 cycles.
// - Skip when register bit high, no flags changed, 1/2/3 cycles.
// - Skip on I/O bit low or high, no flags changed, 1/2/3 cycles.
// - Branch on status flag high or low to PC+k+1, one or two cycles.
// - Compare immediate dst-K not stored, flags Z N V C H, one cycle.
// - Unsigned greater-equal branch equals no-carry branch, one or two cycles.
module ceb_execute (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Instruction request.
  input wire logic req_valid_i,
  input wire ceb_pkg::ceb_req_t req_i,
  output logic req_ready_o,
  // Completion.
  output logic done_o,
  output ceb_pkg::ceb_res_t res_o
);

  typedef struct packed {
    logic active;
    logic [ceb_pkg::CYC_W-1:0] left;
    ceb_pkg::ceb_res_t res;
  } ceb_state_t;

  ceb_state_t st;
  ceb_state_t next_st;

  logic [ceb_pkg::WORD_W-1:0] mul_product;
  logic mul_carry;
  logic mul_zero;
  logic take;
  logic last;
  ceb_pkg::ceb_res_t calc_res;
  logic [ceb_pkg::CYC_W-1:0] calc_cyc;

  // The multiplier sees every request; only the two product ops use its result.
  ceb_mixed_mul u_mul (
    .signed_i(req_i.dst),
    .unsigned_i(req_i.src),
    .fraction_i(req_i.op == ceb_pkg::OP_MIXED_FRACTION),
    .product_o(mul_product),
    .carry_o(mul_carry),
    .zero_o(mul_zero)
  );

  // Eight-bit add with carry in and the half, overflow and carry outputs.
  function automatic ceb_pkg::ceb_alu_t add8(
    input logic [ceb_pkg::DATA_W-1:0] a,
    input logic [ceb_pkg::DATA_W-1:0] b,
    input logic cin
  );
    ceb_pkg::ceb_alu_t o;
    logic [ceb_pkg::DATA_W-1:0] r;
    r = a + b + {7'h00, cin};
    o.val = r;
    o.h = (a[ceb_pkg::NIB_MSB] & b[ceb_pkg::NIB_MSB]) | (b[ceb_pkg::NIB_MSB] &
          ~r[ceb_pkg::NIB_MSB]) | (~r[ceb_pkg::NIB_MSB] & a[ceb_pkg::NIB_MSB]);
    o.v = (a[ceb_pkg::BYTE_MSB] & b[ceb_pkg::BYTE_MSB] & ~r[ceb_pkg::BYTE_MSB]) |
          (~a[ceb_pkg::BYTE_MSB] & ~b[ceb_pkg::BYTE_MSB] & r[ceb_pkg::BYTE_MSB]);
    o.c = (a[ceb_pkg::BYTE_MSB] & b[ceb_pkg::BYTE_MSB]) | (b[ceb_pkg::BYTE_MSB] &
          ~r[ceb_pkg::BYTE_MSB]) | (~r[ceb_pkg::BYTE_MSB] & a[ceb_pkg::BYTE_MSB]);
    return o;
  endfunction

  // Eight-bit subtract with borrow in; carry means a borrow was taken.
  function automatic ceb_pkg::ceb_alu_t sub8(
    input logic [ceb_pkg::DATA_W-1:0] a,
    input logic [ceb_pkg::DATA_W-1:0] b,
    input logic bin
  );
    ceb_pkg::ceb_alu_t o;
    logic [ceb_pkg::DATA_W-1:0] r;
    r = a - b - {7'h00, bin};
    o.val = r;
    o.h = (~a[ceb_pkg::NIB_MSB] & b[ceb_pkg::NIB_MSB]) | (b[ceb_pkg::NIB_MSB] &
          r[ceb_pkg::NIB_MSB]) | (r[ceb_pkg::NIB_MSB] & ~a[ceb_pkg::NIB_MSB]);
    o.v = (a[ceb_pkg::BYTE_MSB] & ~b[ceb_pkg::BYTE_MSB] & ~r[ceb_pkg::BYTE_MSB]) |
          (~a[ceb_pkg::BYTE_MSB] & b[ceb_pkg::BYTE_MSB] & r[ceb_pkg::BYTE_MSB]);
    o.c = (~a[ceb_pkg::BYTE_MSB] & b[ceb_pkg::BYTE_MSB]) | (b[ceb_pkg::BYTE_MSB] &
          r[ceb_pkg::BYTE_MSB]) | (r[ceb_pkg::BYTE_MSB] & ~a[ceb_pkg::BYTE_MSB]);
    return o;
  endfunction

  // Arithmetic byte result: fills Z C N V H and leaves the other flags alone.
  function automatic logic [ceb_pkg::DATA_W-1:0] arith_flags(
    input logic [ceb_pkg::DATA_W-1:0] f,
    input ceb_pkg::ceb_alu_t a,
    input logic chain_zero
  );
    logic [ceb_pkg::DATA_W-1:0] o;
    o = f;
    o[ceb_pkg::FLAG_Z] = (a.val == ceb_pkg::ALL_ZERO) & chain_zero;
    o[ceb_pkg::FLAG_C] = a.c;
    o[ceb_pkg::FLAG_N] = a.val[ceb_pkg::BYTE_MSB];
    o[ceb_pkg::FLAG_V] = a.v;
    o[ceb_pkg::FLAG_H] = a.h;
    return o;
  endfunction

  // Logical byte result: Z N V only, overflow always cleared.
  function automatic logic [ceb_pkg::DATA_W-1:0] logic_flags(
    input logic [ceb_pkg::DATA_W-1:0] f,
    input logic [ceb_pkg::DATA_W-1:0] r
  );
    logic [ceb_pkg::DATA_W-1:0] o;
    o = f;
    o[ceb_pkg::FLAG_Z] = (r == ceb_pkg::ALL_ZERO);
    o[ceb_pkg::FLAG_N] = r[ceb_pkg::BYTE_MSB];
    o[ceb_pkg::FLAG_V] = 1'b0;
    return o;
  endfunction

  // Result and cycle count of the instruction offered on the request port.
  always_comb begin
    ceb_pkg::ceb_alu_t alu;
    logic [ceb_pkg::WORD_W-1:0] wsum;
    logic [ceb_pkg::WORD_W-1:0] wimm;
    logic [ceb_pkg::PC_W-1:0] pc_next;
    logic [ceb_pkg::PC_W-1:0] pc_branch;
    logic [ceb_pkg::PC_W-1:0] pc_skip;
    logic [ceb_pkg::CYC_W-1:0] cyc_skip;
    logic [ceb_pkg::DATA_W-1:0] logic_val;
    logic cond;
    logic wide_msb;
    logic pair_msb;
    alu = '0;
    wsum = '0;
    wimm = {10'h000, req_i.src[ceb_pkg::WIMM_W-1:0]};
    pc_next = req_i.pc + ceb_pkg::PC_STEP;
    pc_branch = pc_next + {{9{req_i.k_off[ceb_pkg::KOFF_W-1]}}, req_i.k_off};
    pc_skip = req_i.next_two_word ? req_i.pc + ceb_pkg::PC_SKIP_TWO
                                  : req_i.pc + ceb_pkg::PC_SKIP_ONE;
    cyc_skip = req_i.next_two_word ? ceb_pkg::CYC_THREE : ceb_pkg::CYC_TWO;
    logic_val = '0;
    cond = 1'b0;
    wide_msb = 1'b0;
    pair_msb = req_i.pair[ceb_pkg::WORD_MSB];
    calc_res = '0;
    calc_res.flags_val = req_i.flags;
    calc_res.pc_val = pc_next;
    calc_cyc = ceb_pkg::CYC_ONE;
    case (req_i.op)
      ceb_pkg::OP_ADD_CARRY: begin
        alu = add8(req_i.dst, req_i.src, req_i.flags[ceb_pkg::FLAG_C]);
        calc_res.dst_we = 1'b1;
        calc_res.dst_val = alu.val;
        calc_res.flags_val = arith_flags(req_i.flags, alu, 1'b1);
      end
      ceb_pkg::OP_SUB_WITH_BORROW, ceb_pkg::OP_SUB_IMM_BORROW: begin
        // Zero only stays set across a chain of borrow subtractions.
        alu = sub8(req_i.dst, req_i.src, req_i.flags[ceb_pkg::FLAG_C]);
        calc_res.dst_we = 1'b1;
        calc_res.dst_val = alu.val;
        calc_res.flags_val = arith_flags(req_i.flags, alu, req_i.flags[ceb_pkg::FLAG_Z]);
      end
      ceb_pkg::OP_SUB_IMMEDIATE, ceb_pkg::OP_COMPARE_IMMEDIATE: begin
        alu = sub8(req_i.dst, req_i.src, 1'b0);
        calc_res.dst_we = (req_i.op == ceb_pkg::OP_SUB_IMMEDIATE);
        calc_res.dst_val = alu.val;
        calc_res.flags_val = arith_flags(req_i.flags, alu, 1'b1);
      end
      ceb_pkg::OP_WORD_ADD_IMM, ceb_pkg::OP_WORD_SUB_IMM: begin
        calc_cyc = ceb_pkg::CYC_TWO;
        if (req_i.op == ceb_pkg::OP_WORD_ADD_IMM) begin
          wsum = req_i.pair + wimm;
          wide_msb = wsum[ceb_pkg::WORD_MSB];
          calc_res.flags_val[ceb_pkg::FLAG_V] = ~pair_msb & wide_msb;
          calc_res.flags_val[ceb_pkg::FLAG_C] = pair_msb & ~wide_msb;
        end else begin
          wsum = req_i.pair - wimm;
          wide_msb = wsum[ceb_pkg::WORD_MSB];
          calc_res.flags_val[ceb_pkg::FLAG_V] = pair_msb & ~wide_msb;
          calc_res.flags_val[ceb_pkg::FLAG_C] = ~pair_msb & wide_msb;
        end
        calc_res.pair_we = 1'b1;
        calc_res.pair_val = wsum;
        calc_res.flags_val[ceb_pkg::FLAG_Z] = (wsum == '0);
        calc_res.flags_val[ceb_pkg::FLAG_N] = wide_msb;
        calc_res.flags_val[ceb_pkg::FLAG_S] = wide_msb ^ calc_res.flags_val[ceb_pkg::FLAG_V];
      end
      ceb_pkg::OP_MASK_IMMEDIATE, ceb_pkg::OP_MERGE_IMMEDIATE, ceb_pkg::OP_BIT_SET_MASK,
      ceb_pkg::OP_BIT_CLEAR_MASK, ceb_pkg::OP_ZERO_SIGN_TEST: begin
        if (req_i.op == ceb_pkg::OP_MASK_IMMEDIATE) begin
          logic_val = req_i.dst & req_i.src;
        end else if (req_i.op == ceb_pkg::OP_BIT_CLEAR_MASK) begin
          logic_val = req_i.dst & (ceb_pkg::ALL_ONES - req_i.src);
        end else if (req_i.op == ceb_pkg::OP_ZERO_SIGN_TEST) begin
          logic_val = req_i.dst & req_i.dst;
        end else begin
          logic_val = req_i.dst | req_i.src;
        end
        calc_res.dst_we = (req_i.op != ceb_pkg::OP_ZERO_SIGN_TEST);
        calc_res.dst_val = logic_val;
        calc_res.flags_val = logic_flags(req_i.flags, logic_val);
      end
      ceb_pkg::OP_MIXED_PRODUCT, ceb_pkg::OP_MIXED_FRACTION: begin
        calc_cyc = ceb_pkg::CYC_TWO;
        calc_res.prod_we = 1'b1;
        calc_res.prod_val = mul_product;
        calc_res.flags_val[ceb_pkg::FLAG_Z] = mul_zero;
        calc_res.flags_val[ceb_pkg::FLAG_C] = mul_carry;
      end
      ceb_pkg::OP_POINTER_JUMP: begin
        calc_cyc = ceb_pkg::CYC_TWO;
        calc_res.pc_val = req_i.zptr;
      end
      ceb_pkg::OP_POINTER_CALL: begin
        calc_cyc = ceb_pkg::CYC_CALL;
        calc_res.pc_val = req_i.zptr;
        calc_res.push_we = 1'b1;
        // Only the return point is handed over; the stack write belongs to the core.
        calc_res.push_val = pc_next;
      end
      ceb_pkg::OP_SKIP_REG_BIT_LOW, ceb_pkg::OP_SKIP_REG_BIT_HIGH,
      ceb_pkg::OP_SKIP_IO_BIT_LOW, ceb_pkg::OP_SKIP_IO_BIT_HIGH: begin
        if (req_i.op == ceb_pkg::OP_SKIP_REG_BIT_LOW) begin
          cond = ~req_i.dst[req_i.bit_sel];
        end else if (req_i.op == ceb_pkg::OP_SKIP_REG_BIT_HIGH) begin
          cond = req_i.dst[req_i.bit_sel];
        end else if (req_i.op == ceb_pkg::OP_SKIP_IO_BIT_LOW) begin
          cond = ~req_i.io_byte[req_i.bit_sel];
        end else begin
          cond = req_i.io_byte[req_i.bit_sel];
        end
        if (cond) begin
          calc_res.pc_val = pc_skip;
          calc_cyc = cyc_skip;
        end
      end
      ceb_pkg::OP_BRANCH_FLAG_HIGH, ceb_pkg::OP_BRANCH_FLAG_LOW,
      ceb_pkg::OP_BRANCH_UNSIGNED_GE, ceb_pkg::OP_BRANCH_NO_CARRY: begin
        if (req_i.op == ceb_pkg::OP_BRANCH_FLAG_HIGH) begin
          cond = req_i.flags[req_i.bit_sel];
        end else if (req_i.op == ceb_pkg::OP_BRANCH_FLAG_LOW) begin
          cond = ~req_i.flags[req_i.bit_sel];
        end else begin
          cond = ~req_i.flags[ceb_pkg::FLAG_C];
        end
        if (cond) begin
          calc_res.pc_val = pc_branch;
          calc_cyc = ceb_pkg::CYC_TWO;
        end
      end
      default: begin
        calc_cyc = ceb_pkg::CYC_ONE;
      end
    endcase
  end

  // A new instruction may be taken in the last cycle of the one before.
  assign last = st.active && (st.left == ceb_pkg::CYC_ONE);
  assign req_ready_o = !st.active || last;
  assign take = req_valid_i && req_ready_o;
  assign done_o = last;
  assign res_o = st.res;

  // A refused request changes nothing: ready is low, so take stays low and the count runs on.
  // The result is latched at take, so it stands until the next instruction is taken.
  always_comb begin
    next_st = st;
    if (take) begin
      next_st.active = 1'b1;
      next_st.left = calc_cyc;
      next_st.res = calc_res;
    end else if (last) begin
      next_st.active = 1'b0;
      next_st.left = ceb_pkg::CYC_NONE;
    end else if (st.active) begin
      next_st.left = st.left - ceb_pkg::CYC_ONE;
    end
  end

  // Reset clears the result as well, so no stale write enable is seen after it.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // ceb_execute

// file: bench/ceb_execute_checker.sv
`timescale 1ns/10ps

module ceb_execute_checker (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Request side.
  input wire logic req_valid_i,
  input wire ceb_pkg::ceb_req_t req_i,
  input wire logic req_ready_o,
  // Completion side.
  input wire logic done_o,
  input wire ceb_pkg::ceb_res_t res_o
);
  logic take;
  logic signed [15:0] mix_prod;
  logic [15:0] br_target;
  assign take = req_valid_i && req_ready_o;
  assign mix_prod = $signed(req_i.dst) * $signed({1'b0, req_i.src});
  // Sign extension lets a negative offset wrap below the current address.
  assign br_target = req_i.pc + 16'h0001 + {{9{req_i.k_off[6]}}, req_i.k_off};

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_two;
    !done_o ##1 done_o;
  endsequence
  sequence s_three;
    !done_o [*2] ##1 done_o;
  endsequence
  sequence s_four;
    (!done_o && !req_ready_o) [*3] ##1 done_o;
  endsequence

  property p_adc;
    take && req_i.op == ceb_pkg::OP_ADD_CARRY |=> done_o &&
      res_o.dst_val == $past(req_i.dst) + $past(req_i.src) + $past(req_i.flags[0]);
  endproperty
  a_adc: assert property (p_adc) else $error("add with carry wrong");
  property p_wadd;
    take && req_i.op == ceb_pkg::OP_WORD_ADD_IMM |=> (res_o.pair_we &&
      res_o.pair_val == $past(req_i.pair) + $past(req_i.src[5:0])) ##0 s_two;
  endproperty
  a_wadd: assert property (p_wadd) else $error("word add wrong");
  property p_wsub;
    take && req_i.op == ceb_pkg::OP_WORD_SUB_IMM |=> (res_o.pair_we &&
      res_o.pair_val == $past(req_i.pair) - $past(req_i.src[5:0])) ##0 s_two;
  endproperty
  a_wsub: assert property (p_wsub) else $error("word subtract wrong");
  property p_mask;
    take && req_i.op == ceb_pkg::OP_MASK_IMMEDIATE |=> done_o &&
      res_o.dst_val == $past(req_i.dst & req_i.src) &&
      res_o.flags_val[ceb_pkg::FLAG_H] == $past(req_i.flags[ceb_pkg::FLAG_H]) &&
      res_o.flags_val[ceb_pkg::FLAG_C] == $past(req_i.flags[ceb_pkg::FLAG_C]);
  endproperty
  a_mask: assert property (p_mask) else $error("mask wrong");
  property p_clear;
    take && req_i.op == ceb_pkg::OP_BIT_CLEAR_MASK |=>
      res_o.dst_val == $past(req_i.dst & (8'hff - req_i.src));
  endproperty
  a_clear: assert property (p_clear) else $error("bit clear wrong");
  property p_cmp;
    take && req_i.op == ceb_pkg::OP_COMPARE_IMMEDIATE |=> done_o && !res_o.dst_we;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare wrote result");
  property p_prod;
    take && req_i.op == ceb_pkg::OP_MIXED_PRODUCT |=>
      (res_o.prod_we && res_o.prod_val == $past(mix_prod)) ##0 s_two;
  endproperty
  a_prod: assert property (p_prod) else $error("mixed product wrong");
  property p_pjump;
    take && req_i.op == ceb_pkg::OP_POINTER_JUMP |=> (res_o.pc_val == $past(req_i.zptr) &&
      res_o.flags_val == $past(req_i.flags)) ##0 s_two;
  endproperty
  a_pjump: assert property (p_pjump) else $error("pointer jump wrong");
  property p_pcall;
    take && req_i.op == ceb_pkg::OP_POINTER_CALL |=> (res_o.push_we &&
      res_o.push_val == $past(req_i.pc) + 16'h0001 &&
      res_o.pc_val == $past(req_i.zptr)) ##0 s_four;
  endproperty
  a_pcall: assert property (p_pcall) else $error("pointer call wrong");
  property p_skip;
    take && req_i.op == ceb_pkg::OP_SKIP_REG_BIT_LOW && !req_i.dst[req_i.bit_sel] &&
      req_i.next_two_word |=> res_o.pc_val == $past(req_i.pc) + 16'h0003 ##0 s_three;
  endproperty
  a_skip: assert property (p_skip) else $error("two word skip wrong");
  property p_branch;
    take && req_i.op == ceb_pkg::OP_BRANCH_FLAG_HIGH && req_i.flags[req_i.bit_sel] |=>
      (res_o.pc_val == $past(br_target) && res_o.flags_val == $past(req_i.flags)) ##0 s_two;
  endproperty
  a_branch: assert property (p_branch) else $error("taken branch wrong");
endmodule // ceb_execute_checker

bind ceb_execute ceb_execute_checker u_chk (.clk_i(clk_i), .reset_i(reset_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
  .done_o(done_o), .res_o(res_o));

// file: bench/ceb_execute_tb_top.sv
`timescale 1ns/10ps

module ceb_execute_tb_top;
  typedef struct packed {
    logic [4:0] op;
    logic [7:0] dst;
    logic [7:0] src;
    logic [7:0] fl;
    logic [2:0] bs;
    logic [6:0] k;
    logic tw;
    logic [2:0] we;
    logic [15:0] ev;
    logic [7:0] ef;
    logic [15:0] epc;
    logic [2:0] n;
  } ceb_row_t;
  logic clk_i = 1'b0;
  logic reset_i;
  logic req_valid_i;
  ceb_pkg::ceb_req_t req_i;
  logic req_ready_o;
  logic done_o;
  ceb_pkg::ceb_res_t res_o;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  // Fields: op, dst, src, flags, bit, k, two-word, writes, value, flags, pc, cycles.
  ceb_row_t rows [31] = '{
  '{5'h00, 8'h0f, 8'h01, 8'h01, 3'h0, 7'h00, 1'h0, 3'h1, 16'h0011, 8'h20, 16'h0101, 3'h1},
  '{5'h01, 8'h00, 8'h01, 8'h00, 3'h0, 7'h00, 1'h0, 3'h2, 16'h8000, 8'h0c, 16'h0101, 3'h2},
  '{5'h02, 8'h00, 8'hff, 8'h3f, 3'h0, 7'h00, 1'h0, 3'h2, 16'h7fc0, 8'h20, 16'h0101, 3'h2},
  '{5'h03, 8'h10, 8'h00, 8'h03, 3'h0, 7'h00, 1'h0, 3'h1, 16'h000f, 8'h20, 16'h0101, 3'h1},
  '{5'h03, 8'h05, 8'h04, 8'h03, 3'h0, 7'h00, 1'h0, 3'h1, 16'h0000, 8'h02, 16'h0101, 3'h1},
  '{5'h04, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 1'h0, 3'h1, 16'h0000, 8'h00, 16'h0101, 3'h1},
  '{5'h05, 8'h80, 8'h01, 8'h00, 3'h0, 7'h00, 1'h0, 3'h1, 16'h007f, 8'h28, 16'h0101, 3'h1},
  '{5'h06, 8'hf0, 8'h8f, 8'h29, 3'h0, 7'h00, 1'h0, 3'h1, 16'h0080, 8'h25, 16'h0101, 3'h1},
  '{5'h07, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 1'h0, 3'h1, 16'h0000, 8'h02, 16'h0101, 3'h1},
  '{5'h08, 8'h01, 8'h80, 8'h00, 3'h0, 7'h00, 1'h0, 3'h1, 16'h0081, 8'h04, 16'h0101, 3'h1},
  '{5'h09, 8'hff, 8'h0f, 8'h08, 3'h0, 7'h00, 1'h0, 3'h1, 16'h00f0, 8'h04, 16'h0101, 3'h1},
  '{5'h0a, 8'h80, 8'h00, 8'h01, 3'h0, 7'h00, 1'h0, 3'h0, 16'h0000, 8'h05, 16'h0101, 3'h1},
  '{5'h0b, 8'hff, 8'h02, 8'h00, 3'h0, 7'h00, 1'h0, 3'h4, 16'hfffe, 8'h01, 16'h0101, 3'h2},
  '{5'h0b, 8'h00, 8'hff, 8'h01, 3'h0, 7'h00, 1'h0, 3'h4, 16'h0000, 8'h02, 16'h0101, 3'h2},
  '{5'h0c, 8'hc0, 8'h80, 8'h00, 3'h0, 7'h00, 1'h0, 3'h4, 16'hc000, 8'h01, 16'h0101, 3'h2},
  '{5'h0d, 8'h00, 8'h00, 8'hff, 3'h0, 7'h00, 1'h0, 3'h0, 16'h0000, 8'hff, 16'h1234, 3'h2},
  '{5'h0e, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 1'h0, 3'h0, 16'h0000, 8'h00, 16'h1234, 3'h4},
  '{5'h0f, 8'hfe, 8'h00, 8'h00, 3'h0, 7'h00, 1'h1, 3'h0, 16'h0000, 8'h00, 16'h0103, 3'h3},
  '{5'h0f, 8'h01, 8'h00, 8'h00, 3'h0, 7'h00, 1'h1, 3'h0, 16'h0000, 8'h00, 16'h0101, 3'h1},
  '{5'h10, 8'h80, 8'h00, 8'h00, 3'h7, 7'h00, 1'h1, 3'h0, 16'h0000, 8'h00, 16'h0103, 3'h3},
  '{5'h11, 8'hfb, 8'h00, 8'hff, 3'h2, 7'h00, 1'h1, 3'h0, 16'h0000, 8'hff, 16'h0103, 3'h3},
  '{5'h11, 8'h04, 8'h00, 8'h00, 3'h2, 7'h00, 1'h0, 3'h0, 16'h0000, 8'h00, 16'h0101, 3'h1},
  '{5'h12, 8'h04, 8'h00, 8'h00, 3'h2, 7'h00, 1'h0, 3'h0, 16'h0000, 8'h00, 16'h0102, 3'h2},
  '{5'h13, 8'h00, 8'h00, 8'h40, 3'h6, 7'h3f, 1'h0, 3'h0, 16'h0000, 8'h40, 16'h0140, 3'h2},
  '{5'h13, 8'h00, 8'h00, 8'h00, 3'h6, 7'h3f, 1'h0, 3'h0, 16'h0000, 8'h00, 16'h0101, 3'h1},
  '{5'h14, 8'h00, 8'h00, 8'h00, 3'h1, 7'h40, 1'h0, 3'h0, 16'h0000, 8'h00, 16'h00c1, 3'h2},
  '{5'h15, 8'h05, 8'h06, 8'h00, 3'h0, 7'h00, 1'h0, 3'h0, 16'h0000, 8'h25, 16'h0101, 3'h1},
  '{5'h16, 8'h00, 8'h00, 8'h00, 3'h0, 7'h02, 1'h0, 3'h0, 16'h0000, 8'h00, 16'h0103, 3'h2},
  '{5'h16, 8'h00, 8'h00, 8'h01, 3'h0, 7'h02, 1'h0, 3'h0, 16'h0000, 8'h01, 16'h0101, 3'h1},
  '{5'h17, 8'h00, 8'h00, 8'h00, 3'h0, 7'h7f, 1'h0, 3'h0, 16'h0000, 8'h00, 16'h0100, 3'h2},
  '{5'h18, 8'h00, 8'h00, 8'h5a, 3'h0, 7'h00, 1'h0, 3'h0, 16'h0000, 8'h5a, 16'h0101, 3'h1}};

  ceb_execute DUT (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o), .res_o(res_o));

  always #5 clk_i = ~clk_i;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_idle();
    chk("ready done", 16'h0002, {14'h0000, req_ready_o, done_o});
    chk("result cleared", 16'h0000, {15'h0000, |res_o});
  endtask

  // Entered at a falling edge while the block is idle or in its last cycle.
  task automatic run(input ceb_row_t r);
    int cnt;
    logic [15:0] got;
    logic [2:0] wr;
    logic call;
    req_valid_i = 1'b1;
    req_i = '{op: ceb_pkg::ceb_op_t'(r.op), dst: r.dst, src: r.src, pair: 16'h7fff,
      zptr: 16'h1234, pc: 16'h0100, flags: r.fl, bit_sel: r.bs, io_byte: r.dst,
      k_off: r.k, next_two_word: r.tw};
    chk("ready", 16'h0001, {15'h0000, req_ready_o});
    @(negedge clk_i);
    req_valid_i = 1'b0;
    cnt = 1;
    while (done_o !== 1'b1 && cnt < 8) begin
      @(negedge clk_i);
      cnt++;
    end
    got = r.we[0] ? {8'h00, res_o.dst_val} : (r.we[1] ? res_o.pair_val : res_o.prod_val);
    chk("cycles", {13'h0000, r.n}, 16'(cnt));
    chk("flags", {8'h00, r.ef}, {8'h00, res_o.flags_val});
    chk("next pc", r.epc, res_o.pc_val);
    if (r.we != 3'h0) begin
      chk("result", r.ev, got);
    end
    wr = {res_o.prod_we, res_o.pair_we, res_o.dst_we};
    call = (r.op == ceb_pkg::OP_POINTER_CALL);
    chk("writes", {13'h0000, r.we}, {13'h0000, wr});
    chk("push", {15'h0000, call}, {15'h0000, res_o.push_we});
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    reset_i = 1'b1;
    req_valid_i = 1'b0;
    req_i = '0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    chk_idle();
    reset_i = 1'b0;
    @(negedge clk_i);
    foreach (rows[i]) begin
      run(rows[i]);
      @(negedge clk_i);
    end
    // The second request is offered in the done cycle of the first.
    run(rows[1]);
    run(rows[2]);
    @(negedge clk_i);
    req_valid_i = 1'b1;
    req_i.op = ceb_pkg::OP_POINTER_CALL;
    @(negedge clk_i);
    chk("busy ready", 16'h0000, {15'h0000, req_ready_o});
    req_valid_i = 1'b0;
    reset_i = 1'b1;
    @(negedge clk_i);
    chk_idle();
    reset_i = 1'b0;
    @(negedge clk_i);
    run(rows[0]);
    end_sim();
  end
endmodule // ceb_execute_tb_top
